//--- core/tzp_defines.vh
// Register offsets, field positions, reset values and timing counts for the timer block
`ifndef TZP_DEFINES_VH
`define TZP_DEFINES_VH

// ****************************************************************
// Register map (byte addresses on the AXI4-Lite bus)
// ****************************************************************
`define TZP_ADDR_COUNT_REGISTER   8'h00
`define TZP_ADDR_OPTION_CONTROL   8'h04
`define TZP_ADDR_WATCHDOG_CMD     8'h08
`define TZP_ADDR_STATUS           8'h0C

// ****************************************************************
// Field positions of count_option_control and the watchdog command clear bit
// ****************************************************************
`define TZP_BIT_SOURCE_SELECT     5
`define TZP_BIT_EDGE_SELECT       4
`define TZP_BIT_OWNER_SELECT      3
`define TZP_RATIO_HI              2
`define TZP_RATIO_LO              0
`define TZP_BIT_WDT_CLEAR         0

// ****************************************************************
// Reset values
// ****************************************************************
`define TZP_OPTION_RESET          8'hFF
`define TZP_COUNT_RESET           8'h00

// ****************************************************************
// Timing: phase clock generation, four system clocks per cycle
// ****************************************************************
`define TZP_PHASES_PER_CYCLE      2'h3
`define TZP_PHASE_TWO             2'h1
`define TZP_PHASE_FOUR            2'h3

// AXI response codes
`define TZP_RESP_OKAY             2'h0
`define TZP_RESP_SLVERR           2'h2

`endif

//--- core/tzp_phase_gen.v
// Four-phase instruction cycle generator for the timer block
`timescale 1ns/1ps

module tzp_phase_gen
(
    clk_sys,
    rstn,
    phase_two,
    phase_four,
    instruction_cycle_clock
);
`include "tzp_defines.vh"
    input  wire       clk_sys;
    input  wire       rstn;
    output reg        phase_two;
    output reg        phase_four;
    output reg        instruction_cycle_clock;

    reg [1:0] phase_reg;

    // ****************************************************************
    // Phase counter: each system clock is one internal phase
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_reg               <= 2'h0;
            phase_two               <= 1'b0;
            phase_four              <= 1'b0;
            instruction_cycle_clock <= 1'b0;
        end
        else
        begin
            phase_reg               <= phase_reg + 2'h1;
            // Strobes mark the phase about to start
            phase_two               <= (phase_reg == (`TZP_PHASE_TWO - 2'h1));
            phase_four              <= (phase_reg == (`TZP_PHASE_FOUR - 2'h1));
            // One pulse per cycle, aligned with the fourth phase
            instruction_cycle_clock <= (phase_reg == (`TZP_PHASE_FOUR - 2'h1));
        end
    end

endmodule // tzp_phase_gen

//--- core/tzp_prescaler.v
// Shared 8-bit prescaler with ratio decode and bypass
`timescale 1ns/1ps

module tzp_prescaler
(
    clk_sys,
    rstn,
    clock_in,
    clear,
    bypass,
    ratio_sel,
    owner_wdt,
    clock_out
);
`include "tzp_defines.vh"
    input  wire       clk_sys;
    input  wire       rstn;
    input  wire       clock_in;
    input  wire       clear;
    input  wire       bypass;
    input  wire [2:0] ratio_sel;
    input  wire       owner_wdt;
    output wire       clock_out;

    reg  [7:0] count_reg;
    wire [3:0] tap;

    // Output tap: 2^(n+1) for the counter, 2^n for the watchdog
    function [3:0] tap_of;
        input [2:0] n;
        input       wdt;
        begin
            tap_of = wdt ? {1'b0, n} : ({1'b0, n} + 4'h1);
        end
    endfunction

    assign tap = tap_of(ratio_sel, owner_wdt);

    // ****************************************************************
    // Ripple-style counter, cleared by writes or watchdog clear
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            count_reg <= 8'h00;
        else if (clear)
            count_reg <= 8'h00;
        else if (clock_in && !bypass)
            count_reg <= count_reg + 8'h01;
    end

    // Divided pulse: one input event in 2^tap completes a full wrap of the low bits
    wire [8:0] wrap_mask = (9'h001 << tap) - 9'h001;
    wire       wrap_hit  = ((count_reg & wrap_mask[7:0]) == wrap_mask[7:0]);

    assign clock_out = bypass ? clock_in : (clock_in && wrap_hit);

endmodule // tzp_prescaler

//--- core/tzp_timer.v
// Timer zero with shared prescaler, AXI4-Lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module tzp_timer
(
    clk_sys,
    rstn,
    ext_count_pin,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    wdt_tick,
    wdt_clear,
    count_value
);
`include "tzp_defines.vh"
    input  wire        clk_sys;
    input  wire        rstn;
    input  wire        ext_count_pin;
    input  wire [7:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output reg         s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output reg         s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output reg         s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    output reg         wdt_tick;
    output reg         wdt_clear;
    output reg  [7:0]  count_value;

    // ****************************************************************
    // Internal state
    // ****************************************************************
    reg  [7:0]  option_reg;
    reg  [7:0]  count_reg;
    reg  [7:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         aw_full_reg;
    reg         w_full_reg;
    reg         pin_sync_reg;
    reg         pin_q2_reg;
    reg         pin_q4_reg;
    reg         pin_prev_reg;

    wire        phase_two;
    wire        phase_four;
    wire        instruction_cycle_clock;
    wire        presc_out;

    wire        count_source_select    = option_reg[`TZP_BIT_SOURCE_SELECT];
    wire        count_edge_select      = option_reg[`TZP_BIT_EDGE_SELECT];
    wire        prescaler_owner_select = option_reg[`TZP_BIT_OWNER_SELECT];
    wire [2:0]  prescale_ratio_select  = option_reg[`TZP_RATIO_HI:`TZP_RATIO_LO];

    // Map a byte address to a hit on one of the defined words
    function addr_is;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_is = ({addr[7:2], 2'b00} == target);
        end
    endfunction

    // Merge write data into an 8-bit register using lane 0 strobe
    function [7:0] merge8;
        input [7:0]  old_val;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge8 = strb[0] ? data[7:0] : old_val;
        end
    endfunction

    // ****************************************************************
    // Phase clocks
    // ****************************************************************
    tzp_phase_gen u_phase
    (
        .clk_sys                 (clk_sys),
        .rstn                    (rstn),
        .phase_two               (phase_two),
        .phase_four              (phase_four),
        .instruction_cycle_clock (instruction_cycle_clock)
    );

    // ****************************************************************
    // External pin: edge selected, then through prescaler when the counter owns it, then sampled
    // ****************************************************************
    // Pin taken synchronous; edge detect on the registered copy
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= ext_count_pin;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Falling edge when edge bit is 1, rising otherwise
    wire pin_edge = count_edge_select ? (pin_prev_reg && !pin_sync_reg)
                                      : (!pin_prev_reg && pin_sync_reg);

    // Source mux: external edges or instruction cycle clock
    wire source_event = count_source_select ? pin_edge : instruction_cycle_clock;

    // Prescaler clears: counter writes when counter owns it, watchdog clear otherwise
    wire cnt_wr;
    wire wdt_cmd_wr;
    wire presc_clear = (cnt_wr && !prescaler_owner_select)
                     || (wdt_cmd_wr && prescaler_owner_select);

    // Shared prescaler; the prescaler feeds whichever unit owns it
    wire presc_in = prescaler_owner_select ? instruction_cycle_clock : source_event;

    // Count has no bus path, only clear, ratio and owner select reach it
    tzp_prescaler u_presc
    (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clock_in  (presc_in),
        .clear     (presc_clear),
        .bypass    (1'b0),
        .ratio_sel (prescale_ratio_select),
        .owner_wdt (prescaler_owner_select),
        .clock_out (presc_out)
    );

    // Counter unprescaled when watchdog owns prescaler: raw event passes
    wire cnt_pulse_raw = prescaler_owner_select ? source_event : presc_out;

    // Hold an event until the phase two sample takes it, wherever in the cycle it lands
    reg pend_reg;
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pend_reg <= 1'b0;
        else if (phase_two)
            pend_reg <= 1'b0;
        else if (cnt_pulse_raw)
            pend_reg <= 1'b1;
    end

    // Two-stage sample on phase two then phase four
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_q2_reg <= 1'b0;
            pin_q4_reg <= 1'b0;
        end
        else
        begin
            if (phase_two)
                pin_q2_reg <= pend_reg || cnt_pulse_raw;
            if (phase_four)
                pin_q4_reg <= pin_q2_reg;
            else
                pin_q4_reg <= 1'b0;
        end
    end

    wire cnt_inc = pin_q4_reg;

    // Watchdog tick: prescaled when it owns the prescaler, raw cycle clock otherwise
    wire wdt_tick_next = prescaler_owner_select ? presc_out : instruction_cycle_clock;

    // ****************************************************************
    // AXI4-Lite write channel: address and data accepted in any order
    // ****************************************************************
    wire wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign cnt_wr     = wr_go && addr_is(aw_addr_reg, `TZP_ADDR_COUNT_REGISTER) && w_strb_reg[0];
    assign wdt_cmd_wr = wr_go && addr_is(aw_addr_reg, `TZP_ADDR_WATCHDOG_CMD) && w_strb_reg[0]
                        && w_data_reg[`TZP_BIT_WDT_CLEAR];
    wire opt_wr = wr_go && addr_is(aw_addr_reg, `TZP_ADDR_OPTION_CONTROL);
    wire wr_ok  = addr_is(aw_addr_reg, `TZP_ADDR_COUNT_REGISTER)
               || addr_is(aw_addr_reg, `TZP_ADDR_OPTION_CONTROL)
               || addr_is(aw_addr_reg, `TZP_ADDR_WATCHDOG_CMD)
               || addr_is(aw_addr_reg, `TZP_ADDR_STATUS);

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TZP_RESP_OKAY;
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !aw_full_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_full_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `TZP_RESP_OKAY : `TZP_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Control and counter registers
    // ****************************************************************
    // Counter write takes priority over an increment in the same cycle
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            option_reg <= `TZP_OPTION_RESET;
            count_reg  <= `TZP_COUNT_RESET;
        end
        else
        begin
            if (opt_wr)
                option_reg <= merge8(option_reg, w_data_reg, w_strb_reg);
            if (cnt_wr)
                count_reg  <= w_data_reg[7:0];  // Ownership untouched here
            else if (cnt_inc)
                count_reg  <= count_reg + 8'h01; // Wraps FF to 00
        end
    end

    // Outputs straight from flip-flops
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wdt_tick    <= 1'b0;
            wdt_clear   <= 1'b0;
            count_value <= 8'h00;
        end
        else
        begin
            wdt_tick    <= wdt_tick_next;
            wdt_clear   <= wdt_cmd_wr;
            count_value <= count_reg;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel: one read at a time, answer in two cycles
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TZP_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `TZP_RESP_OKAY;
                if (addr_is(s_axi_araddr, `TZP_ADDR_COUNT_REGISTER))
                    s_axi_rdata <= {24'h000000, count_reg};
                else if (addr_is(s_axi_araddr, `TZP_ADDR_OPTION_CONTROL))
                    s_axi_rdata <= {24'h000000, option_reg};
                else if (addr_is(s_axi_araddr, `TZP_ADDR_WATCHDOG_CMD))
                    s_axi_rdata <= 32'h0000_0000;
                else if (addr_is(s_axi_araddr, `TZP_ADDR_STATUS))
                    s_axi_rdata <= {30'h0000_0000, pin_sync_reg, prescaler_owner_select};
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `TZP_RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // tzp_timer

//--- verif/tzp_ext_source.sv
// Behavioural external pulse source that drives the count input pin
`timescale 1ns/1ps

module tzp_ext_source
(
    input  wire       clk_sys,
    input  wire       start,
    input  wire [7:0] pulses,
    input  wire       idle_high,
    output wire       ext_count_pin,
    output logic      busy
);
    logic [7:0] left_reg = 8'h00;
    logic [2:0] tick_reg = 3'h0;

    initial busy = 1'b0;

    // Each level lasts four system clocks, as long as the sampling spacing
    always @(posedge clk_sys)
    begin
        if (start && !busy)
        begin
            left_reg <= pulses;
            tick_reg <= 3'h0;
            busy     <= (pulses != 8'h00);
        end
        else if (busy)
        begin
            tick_reg <= tick_reg + 3'h1;
            if (tick_reg == 3'h7)
            begin
                left_reg <= left_reg - 8'h01;
                busy     <= (left_reg != 8'h01);
            end
        end
    end

    // Away from idle in the first half of a pulse; the pin rests at idle between frames
    assign ext_count_pin = busy ? (idle_high ^ ~tick_reg[2]) : idle_high;
endmodule // tzp_ext_source

//--- verif/tzp_timer_checker.sv
// Concurrent checks on the timer block's bus and counter outputs
`timescale 1ns/1ps
`include "tzp_defines.vh"

module tzp_timer_checker
(
    input wire        clk_sys,
    input wire        rstn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        wdt_clear,
    input wire [7:0]  count_value
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Both halves of a write taken together, as the bench offers them
    sequence unmapped_write;
        s_axi_awvalid && s_axi_awready && s_axi_wready && (s_axi_awaddr[7:2] > 6'h03);
    endsequence
    sequence mapped_write;
        s_axi_awvalid && s_axi_awready && s_axi_wready && (s_axi_awaddr[7:2] <= 6'h03);
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_map_slverr: assert property (unmapped_write |=> ##1 s_axi_bvalid &&
        s_axi_bresp == `TZP_RESP_SLVERR) else $error("unmapped write not refused");
    chk_map_okay: assert property (mapped_write |=> ##1 s_axi_bvalid &&
        s_axi_bresp == `TZP_RESP_OKAY) else $error("mapped write not accepted");
    chk_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready longer than one cycle");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_read_latency: assert property (read_taken |=> s_axi_rvalid)
        else $error("read data late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // Away from writes the counter only ever steps by one, wrapping at the top
    chk_count_step: assert property ((!s_axi_bvalid && !$past(s_axi_bvalid) &&
        !$past(s_axi_bvalid, 2) && $changed(count_value)) |->
        count_value == $past(count_value) + 8'h01) else $error("counter jumped");
    chk_clear_cause: assert property (wdt_clear |-> $past(s_axi_wready) ||
        $past(s_axi_wready, 2) || $past(s_axi_wready, 3)) else $error("stray watchdog clear");
    chk_clear_pulse: assert property (wdt_clear |=> !wdt_clear)
        else $error("watchdog clear longer than one cycle");
endmodule // tzp_timer_checker

bind tzp_timer tzp_timer_checker i_chk (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wdt_clear(wdt_clear), .count_value(count_value));

//--- verif/testbench.sv
// Self-checking bench for the timer block with an external pulse source
`timescale 1ns/1ps
`include "tzp_defines.vh"

module testbench;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         wdt_tick, wdt_clear, ext_count_pin, src_busy;
    wire  [7:0]  count_value;
    logic        src_start = 1'b0;
    logic [7:0]  src_pulses = 8'h00;
    logic        src_idle = 1'b0;
    logic        clr_seen = 1'b0;
    int          err_count = 0;
    int          comparisons = 0;
    int          ticks = 0;

    always #10 clk_sys = ~clk_sys;

    tzp_timer i_tzp_timer (.clk_sys(clk_sys), .rstn(rstn), .ext_count_pin(ext_count_pin),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .wdt_tick(wdt_tick), .wdt_clear(wdt_clear), .count_value(count_value));

    tzp_ext_source i_tzp_ext_source (.clk_sys(clk_sys), .start(src_start),
        .pulses(src_pulses), .idle_high(src_idle), .ext_count_pin(ext_count_pin),
        .busy(src_busy));

    // Latch the one-cycle clear pulse and count watchdog steps for later checks
    always @(posedge clk_sys)
    begin
        if (wdt_clear === 1'b1) clr_seen <= 1'b1;
        if (wdt_tick === 1'b1) ticks <= ticks + 1;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task finish_test;
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Address and data offered together; each released once taken
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
    endtask

    task expect_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d, exp);
    endtask

    // Count value within a window, for free-running internal counting
    task expect_near(input logic [7:0] lo, input logic [7:0] hi);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(`TZP_ADDR_COUNT_REGISTER, d, r);
        check({31'h0, d[7:0] >= lo && d[7:0] <= hi && d[31:8] == 24'h0}, 32'h1);
    endtask

    // Settle time covers the synchroniser and counter latency
    task pulses(input logic [7:0] n);
        @(posedge clk_sys);
        src_pulses <= n;
        src_start  <= 1'b1;
        @(posedge clk_sys);
        src_start <= 1'b0;
        @(posedge clk_sys);
        while (src_busy) @(posedge clk_sys);
        repeat (12) @(posedge clk_sys);
    endtask

    task set_idle(input logic v);
        @(posedge clk_sys);
        src_idle <= v;
        repeat (12) @(posedge clk_sys);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset_and_map;
        logic [31:0] d;
        logic [1:0]  r;
        expect_reg(`TZP_ADDR_OPTION_CONTROL, 32'h000000FF);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h00000000);
        expect_reg(`TZP_ADDR_STATUS, 32'h00000001);
        axi_write(8'h10, 32'h0000005A, r);
        check({30'h0, r}, {30'h0, `TZP_RESP_SLVERR});
        axi_read(8'h10, d, r);
        check({30'h0, r}, {30'h0, `TZP_RESP_SLVERR});
    endtask

    task t_internal;
        wr(`TZP_ADDR_OPTION_CONTROL, 32'h02);
        wr(`TZP_ADDR_COUNT_REGISTER, 32'h00);
        repeat (320) @(posedge clk_sys);
        expect_near(8'h09, 8'h0B);
        wr(`TZP_ADDR_OPTION_CONTROL, 32'h08);
        wr(`TZP_ADDR_COUNT_REGISTER, 32'h00);
        repeat (80) @(posedge clk_sys);
        expect_near(8'h12, 8'h15);
    endtask

    task t_external_edges;
        wr(`TZP_ADDR_OPTION_CONTROL, 32'h38);
        wr(`TZP_ADDR_COUNT_REGISTER, 32'h00);
        pulses(8'h03);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h03);
        set_idle(1'b1);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h03);
        wr(`TZP_ADDR_OPTION_CONTROL, 32'h28);
        pulses(8'h03);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h06);
        set_idle(1'b0);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h06);
    endtask

    task t_prescaler_clear;
        wr(`TZP_ADDR_OPTION_CONTROL, 32'h20);
        wr(`TZP_ADDR_COUNT_REGISTER, 32'h00);
        pulses(8'h08);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h04);
        wr(`TZP_ADDR_OPTION_CONTROL, 32'h21);
        wr(`TZP_ADDR_COUNT_REGISTER, 32'h00);
        pulses(8'h03);
        wr(`TZP_ADDR_COUNT_REGISTER, 32'h10);
        pulses(8'h03);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h10);
        pulses(8'h01);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h11);
        expect_reg(`TZP_ADDR_OPTION_CONTROL, 32'h21);
    endtask

    // Ownership moves to the watchdog only after both counts are cleared
    task t_watchdog_owner;
        int t0;
        wr(`TZP_ADDR_COUNT_REGISTER, 32'h00);
        wr(`TZP_ADDR_WATCHDOG_CMD, 32'h01);
        wr(`TZP_ADDR_OPTION_CONTROL, 32'h28);
        @(posedge clk_sys);
        clr_seen <= 1'b0;
        wr(`TZP_ADDR_WATCHDOG_CMD, 32'h01);
        repeat (4) @(posedge clk_sys);
        check({31'h0, clr_seen}, 32'h1);
        t0 = ticks;
        repeat (80) @(posedge clk_sys);
        check(ticks - t0, 32'h14);
        expect_reg(`TZP_ADDR_WATCHDOG_CMD, 32'h00);
        wr(`TZP_ADDR_COUNT_REGISTER, 32'hFF);
        pulses(8'h01);
        expect_reg(`TZP_ADDR_COUNT_REGISTER, 32'h00);
    endtask

    initial
    begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset_and_map;
        t_internal;
        t_external_edges;
        t_prescaler_clear;
        t_watchdog_owner;
        finish_test;
    end

    // Whole run takes about a thousand cycles; a hang is cut well beyond that
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        finish_test;
    end
endmodule // testbench
